// [verilog/acs_sequencer.sv]
// acs_sequencer: sequencing and control of a delta-sigma converter,
// with APB register access, trigger input and end-of-conversion output.
// assumes all inputs synchronous to pclk and a modulator bitstream on mod_bit.
//
// How it works
// R1: multi-sample resets converter between samples
// R2: decimator re-primed before every multi sample
// R3: multi-sample starts next sample by itself
// R4: results readable by polling, interrupt or DMA
// R5: turbo at low resolution acts as multi
// R6: turbo high resolution resets converter once
// R7: trigger input starts a conversion
// R8: trigger driven by clock or programmable logic
// R9: continuous mode needs no trigger
// R10: done output rises at conversion end
// R11: done output serves interrupt or DMA
// R12: four modes, started by bit or trigger
// R13: done holds high until result read
// R14: single: four conversions, result after fourth
// R15: continuous: three priming conversions, then every period
// R16: multi done only after full priming
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.svh"

module acs_sequencer
    import acs_pkg::*;
#(
    parameter logic [`ACS_CNT_W-1:0] CONV_CYCLES = `ACS_CONV_RST
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [`ACS_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   soc,
    input  wire logic                   mod_bit,
    output logic                        mod_reset,
    output logic                        busy,
    input  wire logic                   dma_rd,
    output logic      [`ACS_RES_W-1:0]  result_data,
    output logic                        eoc
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_fast(input acs_mode_t m, input logic [4:0] r);
        is_fast = (m == ACS_TURBO) && (r >= `ACS_TURBO_RES);
    endfunction : is_fast

    function automatic logic [`ACS_RES_W-1:0] res_mask(input logic [4:0] r);
        logic [`ACS_RES_W-1:0] m;
        m = '0;
        for (int i = 0; i < `ACS_RES_W; i++) begin
            m[i] = (5'(i) < r);
        end
        res_mask = m;
    endfunction : res_mask

    ////////////////////////////////////////////////////////////////////////
    // state

    acs_state_t              state_q;
    acs_state_t              state_d;
    acs_mode_t               mode_q;
    logic [4:0]              res_q;
    logic [`ACS_CNT_W-1:0]   conv_len_q;
    logic [`ACS_CNT_W-1:0]   cyc_q;
    logic [`ACS_CNT_W-1:0]   ones_q;
    logic [`ACS_CNT_W-1:0]   hist_q [0:2];
    logic [1:0]              prime_q;
    logic [`ACS_RES_W-1:0]   result_q;
    logic                    done_q;
    logic                    done_d;
    logic                    ovr_q;
    logic                    mod_reset_q;
    logic                    soc_q;
    logic [31:0]             prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire logic acc      = psel & penable;
    wire logic wr_en    = acc & pwrite;
    wire logic rd_acc   = acc & ~pwrite;
    wire logic setup_rd = psel & ~penable & ~pwrite;
    wire logic sel_ctrl = (paddr == `ACS_OFF_CTRL);
    wire logic sel_conv = (paddr == `ACS_OFF_CONV);
    wire logic sel_stat = (paddr == `ACS_OFF_STATUS);
    wire logic sel_res  = (paddr == `ACS_OFF_RESULT);
    wire logic hit      = sel_ctrl | sel_conv | sel_stat | sel_res;

    wire logic [31:0] rd_word =
        sel_ctrl ? {19'h0, res_q, 2'h0, mode_q, 4'h0} :
        sel_conv ? {16'h0, conv_len_q} :
        sel_stat ? {25'h0, state_q, 1'h0, ovr_q, busy, done_q} :
        sel_res  ? {12'h0, result_q} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    wire logic start_req = (wr_en & sel_ctrl & pwdata[`ACS_CTRL_START])
                         | (soc & ~soc_q);                      // R7 R9 R12
    wire logic stop_req  = wr_en & sel_ctrl & pwdata[`ACS_CTRL_STOP];
    wire logic fast      = is_fast(mode_q, res_q);
    wire logic rearm     = (mode_q == ACS_MULTI)
                         | ((mode_q == ACS_TURBO) & ~fast);     // R5
    wire logic converting = (state_q == ACS_ST_CONV);
    wire logic cyc_last  = ({1'b0, cyc_q} + 17'h1) >= {1'b0, conv_len_q};
    wire logic conv_end  = converting & cyc_last;
    wire logic prime_done = (prime_q == `ACS_PRIME_LAST);
    wire logic res_valid = conv_end & prime_done;               // R14 R15 R16
    wire logic rd_clr    = (rd_acc & sel_res) | dma_rd;         // R4 R13

    wire logic [`ACS_CNT_W-1:0] sample_cnt = ones_q + {15'h0, mod_bit};
    wire logic [`ACS_CNT_W+1:0] sum =
        {2'h0, hist_q[0]} + {2'h0, hist_q[1]}
        + {2'h0, hist_q[2]} + {2'h0, sample_cnt};
    wire logic [`ACS_RES_W-1:0] res_masked =
        {2'h0, sum} & res_mask(res_q);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ACS_ST_IDLE: begin
                if (start_req) begin
                    state_d = ACS_ST_PRIME;                     // R7 R12
                end
            end
            ACS_ST_PRIME: begin
                state_d = ACS_ST_CONV;
            end
            ACS_ST_CONV: begin
                if (res_valid && mode_q == ACS_SINGLE) begin
                    state_d = ACS_ST_IDLE;                      // R14
                end else if (res_valid && rearm) begin
                    state_d = ACS_ST_PRIME;                     // R1 R3
                end
            end
            default: begin
                state_d = ACS_ST_IDLE;
            end
        endcase
        if (stop_req) begin
            state_d = ACS_ST_IDLE;
        end
    end

    // continuous and fast turbo stay converting: no reset per sample
    assign done_d = res_valid | (done_q & ~rd_clr);             // R13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACS_ST_IDLE;
            soc_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            soc_q   <= soc;
        end
    end

    // converter reset on each prime, and once at the end in fast turbo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_reset_q <= 1'b0;
        end else begin
            mod_reset_q <= (state_d == ACS_ST_PRIME)
                         | (stop_req & converting & fast);      // R1 R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decimator

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q   <= '0;
            ones_q  <= '0;
            prime_q <= 2'h0;
        end else if (state_q == ACS_ST_PRIME) begin
            cyc_q   <= '0;
            ones_q  <= '0;
            prime_q <= 2'h0;                                    // R2
        end else if (converting) begin
            cyc_q  <= cyc_last ? '0 : cyc_q + 16'h1;
            ones_q <= cyc_last ? '0 : sample_cnt;
            if (cyc_last && !prime_done) begin
                prime_q <= prime_q + 2'h1;
            end
        end
    end

    // pipeline of the last conversion counts
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_hist
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hist_q[g] <= '0;
                end else if (state_q == ACS_ST_PRIME) begin
                    hist_q[g] <= '0;                            // R2
                end else if (conv_end) begin
                    hist_q[g] <= (g == 2) ? sample_cnt : hist_q[(g + 1) % 3];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // result and completion

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= '0;
            done_q   <= 1'b0;
            ovr_q    <= 1'b0;
        end else begin
            if (res_valid) begin
                result_q <= res_masked;                         // R10
            end
            done_q <= done_d;                                   // R10 R13
            if (res_valid && done_q && !rd_clr) begin
                ovr_q <= 1'b1;
            end else if (wr_en && sel_stat && pwdata[`ACS_STAT_OVR]) begin
                ovr_q <= 1'b0;
            end
        end
    end

    assign eoc         = done_q;                                // R11
    assign result_data = result_q;
    assign mod_reset   = mod_reset_q;
    assign busy        = (state_q != ACS_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= acs_mode_t'(`ACS_MODE_RST);
            res_q      <= `ACS_RES_RST;
            conv_len_q <= CONV_CYCLES;
        end else if (wr_en && sel_ctrl) begin
            mode_q <= acs_mode_t'(pwdata[`ACS_CTRL_MODE]);
            res_q  <= pwdata[`ACS_CTRL_RES];
        end else if (wr_en && sel_conv) begin
            conv_len_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_rd) begin
            prdata_q <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_multi_reset;
        res_valid && mode_q == ACS_MULTI && !stop_req |=> mod_reset_q;
    endproperty
    a_multi_reset: assert property (p_multi_reset) else $error("no reset between samples"); // R1

    property p_reprime;
        state_q == ACS_ST_PRIME |=> prime_q == 2'h0 && ones_q == '0 && (converting || $past(stop_req));
    endproperty
    a_reprime: assert property (p_reprime) else $error("decimator not re-primed"); // R2

    property p_auto_next;
        res_valid && rearm && !stop_req |=> state_q == ACS_ST_PRIME ##1 (converting || $past(stop_req));
    endproperty
    a_auto_next: assert property (p_auto_next) else $error("next sample not started"); // R3

    property p_fast_turbo;
        converting && fast && !stop_req |=> !mod_reset_q && state_q != ACS_ST_PRIME;
    endproperty
    a_fast_turbo: assert property (p_fast_turbo) else $error("fast turbo reset mid run"); // R6

    property p_start;
        state_q == ACS_ST_IDLE && start_req && !stop_req |=> mod_reset_q ##1 (converting || $past(stop_req));
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // R7

    property p_cont;
        converting && mode_q == ACS_CONT && !stop_req |=> converting;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode left converting"); // R15

    property p_eoc;
        res_valid |=> eoc && result_data == $past(res_masked);
    endproperty
    a_eoc: assert property (p_eoc) else $error("done or result missing"); // R10

    property p_hold;
        eoc && !rd_clr |=> eoc;
    endproperty
    a_hold: assert property (p_hold) else $error("done dropped before read"); // R13

    property p_single;
        res_valid && mode_q == ACS_SINGLE && !stop_req |=> state_q == ACS_ST_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("single did not return idle"); // R14

    property p_primed;
        $rose(done_q) |-> $past(prime_q) == 2'h3 && $past(converting);
    endproperty
    a_primed: assert property (p_primed) else $error("done before priming"); // R16

    property p_turbo_low;
        res_valid && mode_q == ACS_TURBO && !fast && !stop_req |=> mod_reset_q && state_q == ACS_ST_PRIME;
    endproperty
    a_turbo_low: assert property (p_turbo_low) else $error("low resolution turbo not like multi"); // R5

    property p_trigger;
        state_q == ACS_ST_IDLE && soc && !soc_q && !stop_req |=> state_q == ACS_ST_PRIME;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger edge not taken"); // R7

    property p_clear;
        eoc && rd_clr && !res_valid |=> !eoc;
    endproperty
    a_clear: assert property (p_clear) else $error("done not cleared by read"); // R13

    property p_stop;
        stop_req |=> !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not reach idle"); // R12

endmodule : acs_sequencer
`default_nettype wire

// [verilog/acs_defs.svh]
// acs_defs.svh: register map, field positions and reset values of the
// conversion sequencer; definitions only, included by its bare name.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_ADDR_W      8
`define ACS_OFF_CTRL    8'h00
`define ACS_OFF_CONV    8'h04
`define ACS_OFF_STATUS  8'h08
`define ACS_OFF_RESULT  8'h0C

`define ACS_CTRL_START  0
`define ACS_CTRL_STOP   1
`define ACS_CTRL_MODE   5:4
`define ACS_CTRL_RES    12:8
`define ACS_STAT_DONE   0
`define ACS_STAT_BUSY   1
`define ACS_STAT_OVR    2

`define ACS_MODE_RST    2'h0
`define ACS_RES_RST     5'h10
`define ACS_CONV_RST    16'h0040
`define ACS_TURBO_RES   5'h11
`define ACS_PRIME_LAST  2'h3
`define ACS_RES_W       20
`define ACS_CNT_W       16

`endif

// [verilog/acs_pkg.sv]
// acs_pkg: types shared by the conversion sequencer.
// assumes acs_defs.svh is on the include path.
`include "acs_defs.svh"

package acs_pkg;

    typedef enum logic [1:0] {
        ACS_SINGLE = 2'h0,
        ACS_MULTI  = 2'h1,
        ACS_CONT   = 2'h2,
        ACS_TURBO  = 2'h3
    } acs_mode_t;

    typedef enum logic [2:0] {
        ACS_ST_IDLE  = 3'h1,
        ACS_ST_PRIME = 3'h2,
        ACS_ST_CONV  = 3'h4
    } acs_state_t;

endpackage : acs_pkg

// [verif/acs_partner.sv]
// acs_partner: trigger source and dma reader facing the sequencer.
// assumes one pclk domain; go_trig, dma_en and slow come from the bench.
`timescale 1ns/10ps
`default_nettype none

module acs_partner (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go_trig,
    input  wire logic dma_en,
    input  wire logic slow,
    input  wire logic eoc,
    output logic      soc,
    output logic      dma_rd
);

    logic [2:0] trig_q;
    logic [2:0] wait_q;

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 3'h0;
            soc    <= 1'b0;
            wait_q <= 3'h0;
            dma_rd <= 1'b0;
        end else begin
            // trigger held high a few cycles, like a slow clock
            trig_q <= go_trig ? 3'h4 : trig_q - {2'h0, trig_q != 3'h0};
            soc    <= go_trig | (trig_q != 3'h0);
            // result read once per done, promptly or after a delay
            wait_q <= (eoc && !dma_rd) ? wait_q + 3'h1 : 3'h0;
            dma_rd <= dma_en && eoc && !dma_rd && (!slow || wait_q == 3'h5);
        end
    end

endmodule : acs_partner

`default_nettype wire

// [verif/test_adc_conversion_sequencer.sv]
// test_adc_conversion_sequencer: queue-checked bench for acs_sequencer.
// assumes the design's own assertions are active; partner in acs_partner.sv.
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.svh"

module test_adc_conversion_sequencer
    import acs_pkg::*;
;

    typedef struct {logic [19:0] res; int gap;} acs_note_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        soc, dma_rd, mod_reset, busy, eoc, go_trig, dma_en, slow;
    logic [19:0] result_data;
    logic        mark, watch, fast, mbit;
    logic        eoc_prev = 1'b0;
    int          errors, n_compared, cnt, rst_cnt, cyc, l_cur, g;
    acs_note_t   q[$];
    acs_note_t   nt;
    acs_mode_t   md[4] = '{ACS_MULTI, ACS_CONT, ACS_TURBO, ACS_TURBO};
    logic [4:0]  rs[4] = '{5'h10, 5'h10, 5'h10, 5'h11};

    acs_sequencer #(.CONV_CYCLES(16'h0003)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .soc(soc), .mod_bit(mbit), .mod_reset(mod_reset), .busy(busy), .dma_rd(dma_rd),
        .result_data(result_data), .eoc(eoc));

    acs_partner u_partner (
        .pclk(pclk), .presetn(presetn), .go_trig(go_trig), .dma_en(dma_en), .slow(slow),
        .eoc(eoc), .soc(soc), .dma_rd(dma_rd));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    function automatic acs_note_t note(input int r, input int gp);
        acs_note_t n;
        n.res = r[19:0];
        n.gap = gp;
        return n;
    endfunction : note

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [4:0] r, input logic st,
                                        input logic sp);
        return {19'h0, r, 2'h0, m, 2'h0, sp, st};
    endfunction : ctl

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (wr && a == `ACS_OFF_CTRL && d[0]) mark <= 1'b1;
    endtask : apb

    task automatic drain;
        for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge pclk);
        chk(q.size(), 0);
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end

    // result monitor: gaps counted from start write or previous done
    always @(negedge pclk) begin
        if (mark) begin
            cnt = 1;
            rst_cnt = 0;
            mark = 1'b0;
        end else
            cnt++;
        if (mod_reset === 1'b1) rst_cnt++;
        if (eoc === 1'b1 && eoc_prev !== 1'b1 && watch) begin
            if (q.size() == 0)
                chk(1'b1, 1'b0);
            else begin
                nt = q.pop_front();
                chk(result_data, nt.res);
                if (nt.gap != 0) chk(cnt, nt.gap);
            end
            cnt = 0;
        end
        eoc_prev = eoc;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, go_trig, dma_en, slow, mark} = '0;
        presetn = 1'b0;
        {watch, mbit} = 2'h3;
        void'($urandom(32'hD5C0));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ACS_OFF_CTRL, 32'h0);
        chk(rd, 32'h1000);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        l_cur = 3 + $urandom % 2;
        apb(1'b1, `ACS_OFF_CONV, l_cur);
        // single by start bit, polled and read by cpu
        q.push_back(note(4 * l_cur, 4 * l_cur + 2));
        apb(1'b1, `ACS_OFF_CTRL, ctl(ACS_SINGLE, 5'h10, 1'b1, 1'b0));
        drain();
        apb(1'b0, `ACS_OFF_STATUS, 32'h0);
        chk(rd, 32'h11);
        apb(1'b0, `ACS_OFF_RESULT, 32'h0);
        chk(rd, 4 * l_cur);
        @(negedge pclk);
        chk(eoc, 1'b0);
        // single by trigger, slow dma reader, silent modulator
        @(posedge pclk);
        dma_en <= 1'b1;
        slow <= 1'b1;
        mbit <= 1'b0;
        q.push_back(note(0, 0));
        go_trig <= 1'b1;
        @(posedge pclk);
        go_trig <= 1'b0;
        drain();
        repeat (3) @(negedge pclk);
        chk(eoc, 1'b1);
        repeat (6) @(negedge pclk);
        chk(eoc, 1'b0);
        @(posedge pclk);
        slow <= 1'b0;
        mbit <= 1'b1;
        // streaming modes, prompt dma, trigger left idle
        for (int k = 0; k < 4; k++) begin
            fast = md[k] == ACS_CONT || rs[k] == 5'h11;
            g = fast ? l_cur : 4 * l_cur + 1;
            q.push_back(note(4 * l_cur, 4 * l_cur + 2));
            q.push_back(note(4 * l_cur, g));
            q.push_back(note(4 * l_cur, g));
            apb(1'b1, `ACS_OFF_CTRL, ctl(md[k], rs[k], 1'b1, 1'b0));
            drain();
            watch = 1'b0;
            if (fast)
                chk(rst_cnt, 1);
            else
                chk(rst_cnt >= 3, 1'b1);
            apb(1'b1, `ACS_OFF_CTRL, ctl(md[k], rs[k], 1'b0, 1'b1));
            repeat (12) @(posedge pclk);
            if (md[k] == ACS_TURBO && fast) chk(rst_cnt, 2);
            chk(busy, 1'b0);
            watch = 1'b1;
        end
        test_done();
    end

endmodule : test_adc_conversion_sequencer

`default_nettype wire
